/* src/tcap_timer16.sv */
// Purpose: 16-bit up/down counter with input capture and byte access
// Assumes: timer_tick_in is a one-cycle pulse from an outside prescaler
// Notes:   Compare outputs and waveform logic live elsewhere
//
// Summary of operation
// - 16-bit up/down counter, top and floor flags
// - Counter high location reaches holding register only
// - Counter low read copies high byte
// - Counter low write loads all sixteen bits
// - Tick clears, increments or decrements per mode
// - Tick source zero stops counting, access stays
// - CPU counter write beats count and clear
// - Four-bit mode split over both control registers
// - Overflow flag set per mode, raises interrupt
// - Qualified edge copies counter into capture register
// - Capture flag set with the copy
// - Enabled capture flag requests interrupt; service clears
// - Writing one clears capture flag
// - Capture low read first, copies high byte
// - Capture writable only in capture-ceiling modes
// - Comparator select switches capture source
// - Filter output changes after four equal samples
// - Filter on system clock adds four cycles
// - Capture input off in capture-ceiling modes
// - Capture pin sampled after port output logic
// - Ceiling fixed or from compare A or capture
// - One holding register shared by all words
`timescale 1ns/100ps
module tcap_timer16
  import tcap_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              srst_in,
  // CPU I/O bus
  input  wire logic [LOC_W-1:0]  io_addr_in,
  input  wire logic              io_rd_in,
  input  wire logic              io_wr_in,
  input  wire logic [BYTE_W-1:0] io_wdata_in,
  output logic      [BYTE_W-1:0] io_rdata_out,
  // Tick and capture sources
  input  wire logic              timer_tick_in,
  input  wire logic              capture_pin_in,
  input  wire logic              comparator_output_in,
  input  wire logic              comparator_capture_select_in,
  // Interrupts
  input  wire logic              overflow_irq_ack_in,
  input  wire logic              capture_irq_ack_in,
  output logic                   overflow_irq_out,
  output logic                   capture_irq_out,
  // Counter state
  output logic      [CNT_W-1:0]  counter_value_out,
  output logic                   count_top_out,
  output logic                   count_floor_out
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic logic is_dual(input logic [3:0] m);
    is_dual = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
  endfunction

  function automatic logic cap_top(input logic [3:0] m);
    cap_top = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
  endfunction

  function automatic logic ovf_at_max(input logic [3:0] m);
    ovf_at_max = (m == 4'h0) || (m == 4'h4) || (m == 4'hc) || (m == 4'hd);
  endfunction

  function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] cmpa,
                                           input logic [15:0] capv);
    case (m)
      4'h1, 4'h5: mode_top = TOP_8;
      4'h2, 4'h6: mode_top = TOP_9;
      4'h3, 4'h7: mode_top = TOP_10;
      4'h4, 4'h9, 4'hb, 4'hf: mode_top = cmpa;
      4'h8, 4'ha, 4'hc, 4'he: mode_top = capv;
      default: mode_top = TOP_MAX;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  cap_ff;
  logic [CNT_W-1:0]  cmpa_ff;
  logic [BYTE_W-1:0] temp_ff;
  logic [BYTE_W-1:0] ctrl_a_ff;
  logic [BYTE_W-1:0] ctrl_b_ff;
  logic              ovf_flag_ff;
  logic              cap_flag_ff;
  logic              ovf_ie_ff;
  logic              cap_ie_ff;
  logic [BYTE_W-1:0] rdata_ff;
  tcap_dir_t         dir_ff;

  tcap_capture_if cap_if ();

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  wire rd_cnt_lo  = io_rd_in && (io_addr_in == LOC_CNT_LO);
  wire rd_cap_lo  = io_rd_in && (io_addr_in == LOC_CAP_LO);
  wire wr_cnt_lo  = io_wr_in && (io_addr_in == LOC_CNT_LO);
  wire wr_cap_lo  = io_wr_in && (io_addr_in == LOC_CAP_LO);
  wire wr_cmpa_lo = io_wr_in && (io_addr_in == LOC_CMPA_LO);
  wire wr_ctrl_a  = io_wr_in && (io_addr_in == LOC_CTRL_A);
  wire wr_ctrl_b  = io_wr_in && (io_addr_in == LOC_CTRL_B);
  wire wr_flags   = io_wr_in && (io_addr_in == LOC_FLAGS);
  wire wr_irq_en  = io_wr_in && (io_addr_in == LOC_IRQ_EN);
  wire wr_any_hi  = io_wr_in && ((io_addr_in == LOC_CNT_HI) || (io_addr_in == LOC_CAP_HI) ||
                                 (io_addr_in == LOC_CMPA_HI));

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  wire [3:0]  wgm      = {ctrl_b_ff[CTLB_WGM_LSB+:2], ctrl_a_ff[CTLA_WGM_LSB+:2]};
  wire [2:0]  tick_sel = ctrl_b_ff[CTLB_CS_LSB+:3];
  wire        run_tick = timer_tick_in && (tick_sel != CS_STOP);
  wire [15:0] top_val  = mode_top(wgm, cmpa_ff, cap_ff);
  wire        dual     = is_dual(wgm);
  wire        at_top   = (cnt_ff == top_val);
  wire        at_floor = (cnt_ff == CNT_FLOOR);
  wire        turn_dn  = dual && (dir_ff == DIR_UP) && at_top;
  wire        turn_up  = dual && (dir_ff == DIR_DOWN) && at_floor;
  wire        go_down  = turn_dn || (dual && (dir_ff == DIR_DOWN) && !turn_up);
  wire        clr_cnt  = !dual && at_top;

  // Single slope wraps to floor at the ceiling; dual slope turns round
  wire [15:0] stepped  = clr_cnt ? CNT_FLOOR :
                         (go_down ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001);

  // Write wins over the tick in the same cycle
  wire [15:0] nxt_cnt  = wr_cnt_lo ? {temp_ff, io_wdata_in} :
                         (run_tick ? stepped : cnt_ff);

  wire        nxt_dir_down = !dual ? 1'b0 :
                             (run_tick && !wr_cnt_lo && turn_dn) ? 1'b1 :
                             (run_tick && !wr_cnt_lo && turn_up) ? 1'b0 : (dir_ff == DIR_DOWN);

  wire        ovf_evt  = run_tick && !wr_cnt_lo &&
                         (dual ? turn_up : (ovf_at_max(wgm) ? (cnt_ff == TOP_MAX) : at_top));

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Pin input is taken after the port driver, so software can fire it
  assign cap_if.raw      = comparator_capture_select_in ? comparator_output_in : capture_pin_in;
  assign cap_if.filt_en  = ctrl_b_ff[CTLB_FILT];
  assign cap_if.cap_en   = !cap_top(wgm);
  assign cap_if.rise_sel = ctrl_b_ff[CTLB_EDGE];

  tcap_capture_filter #(
    .SAMPLES (FILT_SAMPLES)
  ) u_filter (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .cap_if  (cap_if)
  );

  wire        capture  = cap_if.capture;
  wire        cap_wr_ok = wr_cap_lo && cap_top(wgm);
  wire [15:0] nxt_cap  = capture ? cnt_ff :
                         (cap_wr_ok ? {temp_ff, io_wdata_in} : cap_ff);

  // ----------------------------------------------------------------
  // Holding register and flags
  // ----------------------------------------------------------------
  // One holding byte for every word; a nested access corrupts it
  wire [7:0]  nxt_temp = wr_any_hi ? io_wdata_in :
                         rd_cnt_lo ? cnt_ff[15:8] :
                         rd_cap_lo ? cap_ff[15:8] : temp_ff;

  // Hardware set beats a software or service clear in the same cycle
  wire nxt_ovf_flag = ovf_evt ||
                      (ovf_flag_ff && !(wr_flags && io_wdata_in[FLG_OVF]) && !overflow_irq_ack_in);
  wire nxt_cap_flag = capture ||
                      (cap_flag_ff && !(wr_flags && io_wdata_in[FLG_CAP]) && !capture_irq_ack_in);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] flags_rd = {6'h00, cap_flag_ff, ovf_flag_ff};
  wire [7:0] ie_rd    = {6'h00, cap_ie_ff, ovf_ie_ff};
  wire [7:0] rd_mux   = (io_addr_in == LOC_CNT_LO)  ? cnt_ff[7:0]  :
                        (io_addr_in == LOC_CNT_HI)  ? temp_ff      :
                        (io_addr_in == LOC_CAP_LO)  ? cap_ff[7:0]  :
                        (io_addr_in == LOC_CAP_HI)  ? temp_ff      :
                        (io_addr_in == LOC_CMPA_LO) ? cmpa_ff[7:0] :
                        (io_addr_in == LOC_CMPA_HI) ? cmpa_ff[15:8] :
                        (io_addr_in == LOC_CTRL_A)  ? ctrl_a_ff    :
                        (io_addr_in == LOC_CTRL_B)  ? ctrl_b_ff    :
                        (io_addr_in == LOC_FLAGS)   ? flags_rd     :
                        (io_addr_in == LOC_IRQ_EN)  ? ie_rd        : RST_BYTE;

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cnt_ff  <= RST_WORD;
      cap_ff  <= RST_WORD;
      cmpa_ff <= RST_WORD;
      temp_ff <= RST_BYTE;
      dir_ff  <= DIR_UP;
    end else begin
      cnt_ff  <= nxt_cnt;
      cap_ff  <= nxt_cap;
      cmpa_ff <= wr_cmpa_lo ? {temp_ff, io_wdata_in} : cmpa_ff;
      temp_ff <= nxt_temp;
      dir_ff  <= nxt_dir_down ? DIR_DOWN : DIR_UP;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl_a_ff   <= RST_BYTE;
      ctrl_b_ff   <= RST_BYTE;
      ovf_flag_ff <= 1'b0;
      cap_flag_ff <= 1'b0;
      ovf_ie_ff   <= 1'b0;
      cap_ie_ff   <= 1'b0;
      rdata_ff    <= RST_BYTE;
    end else begin
      ctrl_a_ff   <= wr_ctrl_a ? io_wdata_in : ctrl_a_ff;
      ctrl_b_ff   <= wr_ctrl_b ? io_wdata_in : ctrl_b_ff;
      ovf_flag_ff <= nxt_ovf_flag;
      cap_flag_ff <= nxt_cap_flag;
      ovf_ie_ff   <= wr_irq_en ? io_wdata_in[FLG_OVF] : ovf_ie_ff;
      cap_ie_ff   <= wr_irq_en ? io_wdata_in[FLG_CAP] : cap_ie_ff;
      rdata_ff    <= io_rd_in ? rd_mux : rdata_ff;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_rdata_out      = rdata_ff;
  assign overflow_irq_out  = ovf_flag_ff && ovf_ie_ff;
  assign capture_irq_out   = cap_flag_ff && cap_ie_ff;
  assign counter_value_out = cnt_ff;
  assign count_top_out     = at_top;
  assign count_floor_out   = at_floor;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cnt_load: assert property (@(posedge mclk_in) disable iff (srst_in)
    wr_cnt_lo |=> cnt_ff == {$past(temp_ff), $past(io_wdata_in)})
    else $error("counter low write did not load both bytes");

  a_write_wins: assert property (@(posedge mclk_in) disable iff (srst_in)
    (wr_cnt_lo && run_tick) |=> cnt_ff[7:0] == $past(io_wdata_in))
    else $error("tick overrode a counter write");

  a_stop_hold: assert property (@(posedge mclk_in) disable iff (srst_in)
    (tick_sel == CS_STOP && !wr_cnt_lo) |=> $stable(cnt_ff))
    else $error("counter moved while stopped");

  a_top_wrap: assert property (@(posedge mclk_in) disable iff (srst_in)
    (run_tick && !dual && at_top && !wr_cnt_lo) |=> cnt_ff == CNT_FLOOR)
    else $error("single slope counter did not wrap at ceiling");

  // Host spaces byte accesses one idle cycle apart
  a_temp_copy: assert property (@(posedge mclk_in) disable iff (srst_in)
    rd_cnt_lo ##1 !(wr_any_hi || rd_cnt_lo || rd_cap_lo) ##1 (io_rd_in && io_addr_in == LOC_CNT_HI)
      |=> io_rdata_out == $past(cnt_ff[15:8], 3))
    else $error("high byte read not coherent with low read");

  a_cap_copy: assert property (@(posedge mclk_in) disable iff (srst_in)
    capture |=> cap_ff == $past(cnt_ff) && cap_flag_ff)
    else $error("capture did not store counter and flag");

  a_cap_gated: assert property (@(posedge mclk_in) disable iff (srst_in)
    (cap_top(wgm) && !cap_wr_ok) |=> $stable(cap_ff))
    else $error("capture fired in a capture-ceiling mode");

  a_flag_clear: assert property (@(posedge mclk_in) disable iff (srst_in)
    (wr_flags && io_wdata_in[FLG_CAP] && !capture) |=> !cap_flag_ff)
    else $error("capture flag not cleared by write of one");

  a_cap_irq: assert property (@(posedge mclk_in) disable iff (srst_in)
    (capture && cap_ie_ff && !wr_irq_en) |=> capture_irq_out)
    else $error("enabled capture did not request interrupt");

  a_hi_cnt_keep: assert property (@(posedge mclk_in) disable iff (srst_in)
    (io_wr_in && io_addr_in == LOC_CNT_HI && !run_tick) |=> $stable(cnt_ff))
    else $error("high location write reached the counter");

  a_hi_to_temp: assert property (@(posedge mclk_in) disable iff (srst_in)
    wr_any_hi |=> temp_ff == $past(io_wdata_in))
    else $error("high write missed the holding register");

  a_lo_rd_copy: assert property (@(posedge mclk_in) disable iff (srst_in)
    rd_cnt_lo |=> temp_ff == $past(cnt_ff[15:8]))
    else $error("counter low read did not save high byte");

  a_cap_rd_copy: assert property (@(posedge mclk_in) disable iff (srst_in)
    rd_cap_lo |=> temp_ff == $past(cap_ff[15:8]))
    else $error("capture low read did not save high byte");

  a_tick_step: assert property (@(posedge mclk_in) disable iff (srst_in)
    (run_tick && !dual && !at_top && !wr_cnt_lo) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter did not step up on tick");

  a_dual_turn: assert property (@(posedge mclk_in) disable iff (srst_in)
    (run_tick && turn_dn && !wr_cnt_lo) |=> dir_ff == DIR_DOWN)
    else $error("dual slope counter did not turn at ceiling");

  a_ovf_set: assert property (@(posedge mclk_in) disable iff (srst_in)
    ovf_evt |=> ovf_flag_ff)
    else $error("overflow event did not set flag");

  a_ovf_ack: assert property (@(posedge mclk_in) disable iff (srst_in)
    (overflow_irq_ack_in && !ovf_evt) |=> !ovf_flag_ff)
    else $error("service did not clear overflow flag");

  a_cap_ack: assert property (@(posedge mclk_in) disable iff (srst_in)
    (capture_irq_ack_in && !capture) |=> !cap_flag_ff)
    else $error("service did not clear capture flag");

  a_flag_keep: assert property (@(posedge mclk_in) disable iff (srst_in)
    (wr_flags && !io_wdata_in[FLG_CAP] && !capture_irq_ack_in && cap_flag_ff) |=> cap_flag_ff)
    else $error("writing zero cleared capture flag");

  a_cap_refuse: assert property (@(posedge mclk_in) disable iff (srst_in)
    (wr_cap_lo && !cap_top(wgm) && !capture) |=> $stable(cap_ff))
    else $error("capture register written outside ceiling modes");

  a_cap_write: assert property (@(posedge mclk_in) disable iff (srst_in)
    (wr_cap_lo && cap_top(wgm)) |=> cap_ff == {$past(temp_ff), $past(io_wdata_in)})
    else $error("capture register write did not load both bytes");

  a_cmpa_load: assert property (@(posedge mclk_in) disable iff (srst_in)
    wr_cmpa_lo |=> cmpa_ff == {$past(temp_ff), $past(io_wdata_in)})
    else $error("compare A write did not use holding byte");

endmodule

/* src/tcap_pkg.sv */
// Purpose: Shared constants for the 16-bit timer counter and capture block
// Assumes: 8-bit CPU I/O bus, one system clock
// Notes:   I/O locations are a 4-bit index within the timer
package tcap_pkg;

  // ----------------------------------------------------------------
  // Widths and I/O locations
  // ----------------------------------------------------------------
  localparam int         CNT_W       = 16;
  localparam int         BYTE_W      = 8;
  localparam int         LOC_W       = 4;
  localparam logic [3:0] LOC_CNT_LO  = 4'h0;
  localparam logic [3:0] LOC_CNT_HI  = 4'h1;
  localparam logic [3:0] LOC_CAP_LO  = 4'h2;
  localparam logic [3:0] LOC_CAP_HI  = 4'h3;
  localparam logic [3:0] LOC_CMPA_LO = 4'h4;
  localparam logic [3:0] LOC_CMPA_HI = 4'h5;
  localparam logic [3:0] LOC_CTRL_A  = 4'h6;
  localparam logic [3:0] LOC_CTRL_B  = 4'h7;
  localparam logic [3:0] LOC_FLAGS   = 4'h8;
  localparam logic [3:0] LOC_IRQ_EN  = 4'h9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTLA_WGM_LSB = 0;
  localparam int CTLB_CS_LSB  = 0;
  localparam int CTLB_WGM_LSB = 3;
  localparam int CTLB_EDGE    = 6;
  localparam int CTLB_FILT    = 7;
  localparam int FLG_OVF      = 0;
  localparam int FLG_CAP      = 1;

  // ----------------------------------------------------------------
  // Reset values, ceilings, timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [15:0] CNT_FLOOR = 16'h0000;
  localparam logic [15:0] TOP_8     = 16'h00ff;
  localparam logic [15:0] TOP_9     = 16'h01ff;
  localparam logic [15:0] TOP_10    = 16'h03ff;
  localparam logic [15:0] TOP_MAX   = 16'hffff;
  localparam logic [2:0]  CS_STOP   = 3'h0;
  localparam int          FILT_SAMPLES = 4;

  typedef enum logic {DIR_UP, DIR_DOWN} tcap_dir_t;

endpackage

/* src/tcap_capture_if.sv */
// Purpose: Signals between the timer core and its capture front end
// Assumes: Both ends on mclk_in
// Notes:   capture is a one-cycle pulse
`timescale 1ns/100ps
interface tcap_capture_if;
  logic raw;
  logic filt_en;
  logic cap_en;
  logic rise_sel;
  logic capture;
  modport core (output raw, output filt_en, output cap_en, output rise_sel, input capture);
  modport unit (input raw, input filt_en, input cap_en, input rise_sel, output capture);
endinterface

/* src/tcap_capture_filter.sv */
// Purpose: Input sampler, optional noise filter and edge detector
// Assumes: raw is synchronous to mclk_in
// Notes:   Filter adds SAMPLES cycles of delay against the plain path
`timescale 1ns/100ps
module tcap_capture_filter
  import tcap_pkg::*;
#(
  parameter int SAMPLES = FILT_SAMPLES
) (
  // Clock and reset
  input  wire logic    mclk_in,
  input  wire logic    srst_in,
  // Core side
  tcap_capture_if.unit cap_if
);

  logic               smp_ff;
  logic [SAMPLES-2:0] hist_ff;
  logic               filt_ff;
  logic               prev_ff;

  wire [SAMPLES-1:0] window = {hist_ff, smp_ff};
  wire               all_hi = &window;
  wire               all_lo = ~|window;
  wire               level  = cap_if.filt_en ? filt_ff : smp_ff;

  // Edge on the chosen polarity; gated off in ceiling modes
  assign cap_if.capture = cap_if.cap_en && (level != prev_ff) && (level == cap_if.rise_sel);

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      smp_ff  <= 1'b0;
      hist_ff <= '0;
      filt_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      smp_ff  <= cap_if.raw;
      hist_ff <= window[SAMPLES-2:0];
      filt_ff <= all_hi ? 1'b1 : (all_lo ? 1'b0 : filt_ff);
      prev_ff <= level;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_filter_agree: assert property (@(posedge mclk_in) disable iff (srst_in)
    !$stable(filt_ff) |-> $past(all_hi || all_lo))
    else $error("filter output changed without four equal samples");

endmodule

/* dv/tcap_host_model.sv */
// Purpose: Host CPU model on the 8-bit timer I/O bus
// Assumes: One byte access per two clocks
// Notes:   Released address and data lines show the inverse of their last value; strobes go low
`timescale 1ns/100ps
module tcap_host_model
  import tcap_pkg::*;
(
  // Clock
  input  wire logic              mclk_in,
  // I/O bus
  output logic      [LOC_W-1:0]  io_addr_out,
  output logic                   io_rd_out,
  output logic                   io_wr_out,
  output logic      [BYTE_W-1:0] io_wdata_out,
  input  wire logic [BYTE_W-1:0] io_rdata_in
);
  initial begin
    io_addr_out  = 4'h0;
    io_rd_out    = 1'b0;
    io_wr_out    = 1'b0;
    io_wdata_out = 8'h00;
  end

  // ----------------------------------------------------------------
  // Byte and word accesses
  // ----------------------------------------------------------------
  // Held through the taking edge; read data valid just after it
  task automatic acc(input logic [3:0] loc, input logic rd, input logic [7:0] d, output logic [7:0] q);
    io_addr_out  = loc;
    io_rd_out    = rd;
    io_wr_out    = ~rd;
    io_wdata_out = d;
    @(posedge mclk_in);
    #1;
    q            = io_rdata_in;
    io_rd_out    = 1'b0;
    io_wr_out    = 1'b0;
    io_addr_out  = ~loc;
    io_wdata_out = ~d;
    @(posedge mclk_in);
    #1;
  endtask

  task automatic wr(input logic [3:0] loc, input logic [7:0] d);
    logic [7:0] q;
    acc(loc, 1'b0, d, q);
  endtask

  task automatic rd(input logic [3:0] loc, output logic [7:0] q);
    acc(loc, 1'b1, 8'h00, q);
  endtask

  // High byte lives at the next location up
  task automatic wr16(input logic [3:0] lo, input logic [15:0] d);
    wr(lo + 4'h1, d[15:8]);
    wr(lo, d[7:0]);
  endtask

  task automatic rd16(input logic [3:0] lo, output logic [15:0] d);
    rd(lo, d[7:0]);
    rd(lo + 4'h1, d[15:8]);
  endtask
endmodule

/* dv/testbench.sv */
// Purpose: Self-checking bench for the timer counter and capture block
// Assumes: Host model drives the I/O bus, bench drives tick and sources
// Notes:   Filter delay judged against the measured plain latency
`timescale 1ns/100ps
module testbench;
  import tcap_pkg::*;
  logic              mclk_in = 1'b0, srst_in = 1'b1;
  logic              tick = 1'b0, pin = 1'b0, cmp = 1'b0, csel = 1'b0, oack = 1'b0, cack = 1'b0;
  logic [LOC_W-1:0]  io_addr;
  logic              io_rd, io_wr, ovf_irq, cap_irq, top, floor_hit;
  logic [BYTE_W-1:0] io_wdata, io_rdata, q;
  logic [CNT_W-1:0]  cnt, w;
  int                mismatches = 0, check_count = 0, n0, n1;

  always #5 mclk_in = ~mclk_in;

  tcap_host_model host (.mclk_in(mclk_in), .io_addr_out(io_addr), .io_rd_out(io_rd), .io_wr_out(io_wr),
                        .io_wdata_out(io_wdata), .io_rdata_in(io_rdata));
  tcap_timer16 uut (.mclk_in(mclk_in), .srst_in(srst_in), .io_addr_in(io_addr), .io_rd_in(io_rd),
                    .io_wr_in(io_wr), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata), .timer_tick_in(tick),
                    .capture_pin_in(pin), .comparator_output_in(cmp), .comparator_capture_select_in(csel),
                    .overflow_irq_ack_in(oack), .capture_irq_ack_in(cack), .overflow_irq_out(ovf_irq),
                    .capture_irq_out(cap_irq), .counter_value_out(cnt), .count_top_out(top),
                    .count_floor_out(floor_hit));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge mclk_in);
    #1;
    s = 1'b0;
    // Low for one edge so a second pulse is a fresh strobe
    @(posedge mclk_in);
    #1;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  task automatic set_mode(input logic [3:0] m, input logic [7:0] b);
    host.wr(LOC_CTRL_A, {6'h00, m[1:0]});
    host.wr(LOC_CTRL_B, b | {3'h0, m[3:2], 3'h0});
  endtask

  // Bounded wait for the capture request
  task automatic wait_cap(output int n);
    n = 0;
    while (cap_irq !== 1'b1 && n < 20) begin
      idle(1);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(cnt, 16'h0000);
    chk({top, floor_hit, ovf_irq, cap_irq}, 16'h0004);
    host.rd(4'hf, q);
    chk(q, 8'h00);
  endtask

  task automatic t_access;
    host.wr16(LOC_CNT_LO, 16'h1234);
    chk(cnt, 16'h1234);
    host.wr(LOC_CNT_HI, 8'h77);
    chk(cnt, 16'h1234);
    host.wr(LOC_CMPA_LO, 8'h56);
    host.rd16(LOC_CMPA_LO, w);
    chk(w, 16'h7756);
    host.rd16(LOC_CNT_LO, w);
    chk(w, 16'h1234);
  endtask

  task automatic t_count;
    pulse(tick);
    chk(cnt, 16'h1234);
    host.wr(LOC_CTRL_B, 8'h01);
    pulse(tick);
    chk(cnt, 16'h1235);
    host.wr(LOC_CNT_HI, 8'h40);
    fork
      host.wr(LOC_CNT_LO, 8'h00);
      pulse(tick);
    join
    chk(cnt, 16'h4000);
  endtask

  task automatic t_modes;
    logic [3:0]  m [4] = '{4'h0, 4'h5, 4'h6, 4'h7};
    logic [15:0] t [4] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff};
    host.wr(LOC_IRQ_EN, 8'h01);
    for (int i = 0; i < 4; i++) begin
      set_mode(m[i], 8'h01);
      host.wr16(LOC_CNT_LO, t[i]);
      chk(top, 1'b1);
      pulse(tick);
      chk(cnt, 16'h0000);
      host.rd(LOC_FLAGS, q);
      chk({q, ovf_irq}, 9'h003);
      host.wr(LOC_FLAGS, 8'h01);
    end
    // Compare A ceiling clears the count; overflow only at the maximum
    set_mode(4'h4, 8'h01);
    host.wr16(LOC_CNT_LO, 16'h7756);
    chk(top, 1'b1);
    pulse(tick);
    chk(cnt, 16'h0000);
    chk(ovf_irq, 1'b0);
    host.wr16(LOC_CNT_LO, 16'hffff);
    pulse(tick);
    chk(ovf_irq, 1'b1);
    pulse(oack);
    chk(ovf_irq, 1'b0);
    set_mode(4'h1, 8'h01);
    host.wr16(LOC_CNT_LO, 16'h00ff);
    pulse(tick);
    chk(cnt, 16'h00fe);
    host.wr16(LOC_CNT_LO, 16'h0001);
    pulse(tick);
    chk(floor_hit, 1'b1);
    pulse(tick);
    chk(cnt, 16'h0001);
    chk(ovf_irq, 1'b1);
  endtask

  task automatic t_capture;
    set_mode(4'h0, 8'h40);
    host.wr(LOC_IRQ_EN, 8'h02);
    host.wr(LOC_FLAGS, 8'h03);
    host.wr16(LOC_CNT_LO, 16'h0abc);
    pin = 1'b1;
    wait_cap(n0);
    host.rd16(LOC_CAP_LO, w);
    chk(w, 16'h0abc);
    host.rd(LOC_FLAGS, q);
    chk(q, 8'h02);
    host.wr(LOC_FLAGS, 8'h00);
    chk(cap_irq, 1'b1);
    host.wr(LOC_FLAGS, 8'h02);
    chk(cap_irq, 1'b0);
    pin = 1'b0;
    idle(10);
    chk(cap_irq, 1'b0);
    host.wr(LOC_CTRL_B, 8'h00);
    pin = 1'b1;
    idle(10);
    chk(cap_irq, 1'b0);
    host.wr16(LOC_CNT_LO, 16'h2222);
    pin = 1'b0;
    wait_cap(n1);
    chk(cap_irq, 1'b1);
    host.wr16(LOC_CNT_LO, 16'h3333);
    pin = 1'b1;
    idle(10);
    pin = 1'b0;
    idle(10);
    host.rd16(LOC_CAP_LO, w);
    chk(w, 16'h3333);
    host.wr(LOC_IRQ_EN, 8'h00);
    chk(cap_irq, 1'b0);
    host.wr(LOC_IRQ_EN, 8'h02);
    pulse(cack);
    chk(cap_irq, 1'b0);
    host.wr(LOC_CTRL_B, 8'hc0);
    host.wr(LOC_FLAGS, 8'h02);
    pin = 1'b1;
    idle(2);
    pin = 1'b0;
    idle(12);
    chk(cap_irq, 1'b0);
    pin = 1'b1;
    wait_cap(n1);
    chk(16'(n1), 16'(n0 + FILT_SAMPLES));
  endtask

  task automatic t_source;
    host.wr(LOC_CTRL_B, 8'h40);
    csel = 1'b1;
    idle(10);
    host.wr(LOC_FLAGS, 8'h02);
    host.wr16(LOC_CNT_LO, 16'h4444);
    cmp = 1'b1;
    wait_cap(n1);
    host.rd16(LOC_CAP_LO, w);
    chk(w, 16'h4444);
    host.wr(LOC_FLAGS, 8'h02);
    pin = 1'b0;
    idle(4);
    pin = 1'b1;
    idle(10);
    chk(cap_irq, 1'b0);
  endtask

  task automatic t_capwrite;
    host.wr16(LOC_CAP_LO, 16'h5566);
    host.rd16(LOC_CAP_LO, w);
    chk(w, 16'h4444);
    set_mode(4'hc, 8'h40);
    host.wr(LOC_FLAGS, 8'h02);
    host.wr16(LOC_CAP_LO, 16'h5566);
    host.rd16(LOC_CAP_LO, w);
    chk(w, 16'h5566);
    host.wr16(LOC_CNT_LO, 16'h5566);
    chk(top, 1'b1);
    cmp = 1'b0;
    idle(4);
    cmp = 1'b1;
    idle(10);
    chk(cap_irq, 1'b0);
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk_in);
    #1;
    srst_in = 1'b0;
    idle(1);
    t_reset;
    t_access;
    t_count;
    t_modes;
    t_capture;
    t_source;
    t_capwrite;
    print_verdict;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    print_verdict;
  end
endmodule
